/* File: src/cim_regs.svh */
// Constants of the card link: frame layout, block sizes, link timing
`ifndef CIM_REGS_SVH
`define CIM_REGS_SVH
`define CIM_FRAME_LEN   6'h30
`define CIM_FRAME_LAST  6'h2F
`define CIM_IDX_MSB     45
`define CIM_IDX_LSB     40
`define CIM_RESET_IDX   6'h00
`define CIM_BYTE_LAST   3'h7
`define CIM_BLK_MAX     12'h800
`define CIM_CLK_NS      10
`define CIM_LCLK_MIN_NS 50
`define CIM_LCLK_HALF   ((`CIM_LCLK_MIN_NS + 2 * `CIM_CLK_NS - 1) / (2 * `CIM_CLK_NS))
`endif

/* File: src/cim_pkg.sv */
// Types shared by both ends of the card link
package cim_pkg;
    typedef logic [47:0] cim_frame_t;
    typedef logic [7:0]  cim_byte_t;
    typedef logic [11:0] cim_len_t;
    typedef enum logic [0:0] {
        CIM_MODE_NATIVE = 1'b0,
        CIM_MODE_SPI    = 1'b1
    } cim_mode_e;
endpackage : cim_pkg

/* File: src/cim_link_if.sv */
// Card link wires with pull-up resolution of the shared pads
`timescale 1ns/1ns
`default_nettype none
interface cim_link_if;
    logic lclk;
    logic cs_n;
    logic cmd_h_o;
    logic cmd_h_oe;
    logic cmd_c_o;
    logic cmd_c_oe;
    logic dat_h_o;
    logic dat_h_oe;
    logic dat_c_o;
    logic dat_c_oe;
    logic cmd_line;
    logic dat_line;
    // Pull-up on both pads: a line is low only when a driver pulls it low
    assign cmd_line = ~((cmd_h_oe & ~cmd_h_o) | (cmd_c_oe & ~cmd_c_o));
    assign dat_line = ~((dat_h_oe & ~dat_h_o) | (dat_c_oe & ~dat_c_o));
    modport card (input lclk, input cs_n, input cmd_line, input dat_line,
                  output cmd_c_o, output cmd_c_oe, output dat_c_o, output dat_c_oe);
    modport host (output lclk, output cs_n, output cmd_h_o, output cmd_h_oe,
                  output dat_h_o, output dat_h_oe, input cmd_line, input dat_line);
endinterface : cim_link_if
`default_nettype wire

/* File: src/cim_card_end.sv */
// Card end of the card link: mode select, command, response and data paths
`timescale 1ns/1ns
`default_nettype none
`include "cim_regs.svh"
// Overview of operation
// - Power-on starts in native three-line mode
// - Reset command with select low enters SPI
// - One bit per link clock per line
// - Host may run link clock 0-20 MHz
// - Command pad open-drain during init, else push-pull
// - Commands host to card, responses card to host
// - Card drives data pad push-pull
// - Card samples link inputs on link clock, retimes words into internal clock
// - Own power-on reset, no master reset pin
// - SPI addressing by chip select only
// - SPI ignores traffic while not selected
// - Host holds select low whole transaction
// - Programming continues after select released
// - SPI: separate in/out lines, no command mid-transfer
// - Single and multiple blocks both supported
// - Read block length 1 to 2048 bytes
// - SPI reuses reserved, command, data pads
module cim_card_end
    import cim_pkg::*;
(
    cim_link_if.card         link,
    input  wire logic        CLK,
    input  wire logic        NRST,
    output logic             CMD_VALID,
    output cim_frame_t       CMD_WORD,
    output logic             SPI_MODE,
    input  wire logic        RESP_VALID,
    input  wire cim_frame_t  RESP_WORD,
    output logic             RESP_READY,
    input  wire logic        OPEN_DRAIN,
    input  wire logic        PROG_BUSY,
    input  wire logic        DTX_VALID,
    input  wire cim_byte_t   DTX_BYTE,
    output logic             DTX_READY,
    input  wire cim_len_t    BLK_LEN,
    output logic             DTX_BLK_END,
    input  wire logic        DRX_ARM,
    output logic             DRX_VALID,
    output cim_byte_t        DRX_BYTE
);
    // Toggle synchroniser edge: second and third stage only
    function automatic logic tgl_edge(input logic [2:0] s);
        return s[2] ^ s[1];
    endfunction : tgl_edge

    // Core-side registers seen by the link domain
    logic       od_core_ff, busy_core_ff, arm_core_ff, rsp_req_ff, dtx_req_ff;
    cim_frame_t rsp_word_ff;
    cim_byte_t  dtx_byte_ff;

    // Link domain state
    cim_mode_e  mode_ff;
    logic [1:0] od_s_ff, busy_s_ff, arm_s_ff, rreq_s_ff, dreq_s_ff;
    logic       rx_busy_ff, cs_lo_ff, frame_tgl_ff;
    logic [5:0] rx_cnt_ff;
    cim_frame_t rx_sh_ff, frame_ff;
    logic       rtx_busy_ff, rsp_ack_ff;
    logic [5:0] rtx_cnt_ff;
    cim_frame_t rtx_sh_ff;
    logic       dtx_busy_ff, dtx_ack_ff;
    logic [2:0] dtx_cnt_ff;
    cim_byte_t  dtx_sh_ff;
    logic       drx_busy_ff, drx_tgl_ff;
    logic [2:0] drx_cnt_ff;
    cim_byte_t  drx_sh_ff, drx_byte_ff;

    // Link-side decode
    wire        spi      = (mode_ff == CIM_MODE_SPI);
    wire        od_l     = od_s_ff[1];
    wire        arm_l    = arm_s_ff[1];
    wire        selected = ~spi | ~link.cs_n;
    wire        xfer     = drx_busy_ff | dtx_busy_ff | arm_l;
    wire        cmd_gate = selected & ~rtx_busy_ff & ~(spi & xfer);
    wire        rx_start = ~rx_busy_ff & cmd_gate & ~link.cmd_line;
    wire        rx_last  = rx_busy_ff & (rx_cnt_ff == `CIM_FRAME_LAST);
    wire        rx_abort = rx_busy_ff & spi & link.cs_n;
    wire [47:0] rx_word  = {rx_sh_ff[46:0], link.cmd_line};
    wire        is_reset = (rx_word[`CIM_IDX_MSB:`CIM_IDX_LSB] == `CIM_RESET_IDX);

    // Level crossings into the link clock
    always_ff @(posedge link.lclk or negedge NRST) begin
        if (!NRST) begin
            od_s_ff   <= 2'h0;
            busy_s_ff <= 2'h0;
            arm_s_ff  <= 2'h0;
            rreq_s_ff <= 2'h0;
            dreq_s_ff <= 2'h0;
        end else begin
            od_s_ff   <= {od_s_ff[0], od_core_ff};
            busy_s_ff <= {busy_s_ff[0], busy_core_ff};
            arm_s_ff  <= {arm_s_ff[0], arm_core_ff};
            rreq_s_ff <= {rreq_s_ff[0], rsp_req_ff};
            dreq_s_ff <= {dreq_s_ff[0], dtx_req_ff};
        end
    end

    // Command receiver and mode latch; power-on reset is the only way out of SPI
    always_ff @(posedge link.lclk or negedge NRST) begin
        if (!NRST) begin
            mode_ff      <= CIM_MODE_NATIVE;
            rx_busy_ff   <= 1'b0;
            rx_cnt_ff    <= 6'h00;
            rx_sh_ff     <= '0;
            cs_lo_ff     <= 1'b0;
            frame_ff     <= '0;
            frame_tgl_ff <= 1'b0;
        end else begin
            if (rx_start | rx_busy_ff) rx_sh_ff <= rx_word;
            if (rx_start) begin
                rx_busy_ff <= 1'b1;
                rx_cnt_ff  <= 6'h01;
                cs_lo_ff   <= ~link.cs_n;
            end else if (rx_abort | rx_last) begin
                rx_busy_ff <= 1'b0;
            end else if (rx_busy_ff) begin
                rx_cnt_ff <= rx_cnt_ff + 6'h01;
            end
            if (rx_last & ~rx_abort) begin
                frame_ff     <= rx_word;
                frame_tgl_ff <= ~frame_tgl_ff;
                if (is_reset & cs_lo_ff & ~link.cs_n) mode_ff <= CIM_MODE_SPI;
            end
        end
    end

    // Response shifter; word stays stable in the core until the ack returns
    wire rtx_load = ~rtx_busy_ff & ~rx_busy_ff & (rreq_s_ff[1] != rsp_ack_ff);
    always_ff @(posedge link.lclk or negedge NRST) begin
        if (!NRST) begin
            rtx_busy_ff <= 1'b0;
            rtx_cnt_ff  <= 6'h00;
            rtx_sh_ff   <= '1;
            rsp_ack_ff  <= 1'b0;
        end else if (rtx_load) begin
            rtx_busy_ff <= 1'b1;
            rtx_cnt_ff  <= `CIM_FRAME_LEN;
            rtx_sh_ff   <= rsp_word_ff;
            rsp_ack_ff  <= ~rsp_ack_ff;
        end else if (rtx_busy_ff) begin
            rtx_sh_ff  <= {rtx_sh_ff[46:0], 1'b1};
            rtx_cnt_ff <= rtx_cnt_ff - 6'h01;
            if (rtx_cnt_ff == 6'h01) rtx_busy_ff <= 1'b0;
        end
    end

    // Data transmit shifter, back to back bytes without a gap
    wire dtx_pend = (dreq_s_ff[1] != dtx_ack_ff);
    wire dtx_end  = dtx_busy_ff & (dtx_cnt_ff == `CIM_BYTE_LAST);
    wire dtx_load = dtx_pend & (~dtx_busy_ff | dtx_end) & selected;
    always_ff @(posedge link.lclk or negedge NRST) begin
        if (!NRST) begin
            dtx_busy_ff <= 1'b0;
            dtx_cnt_ff  <= 3'h0;
            dtx_sh_ff   <= 8'hFF;
            dtx_ack_ff  <= 1'b0;
        end else if (dtx_load) begin
            dtx_busy_ff <= 1'b1;
            dtx_cnt_ff  <= 3'h0;
            dtx_sh_ff   <= dtx_byte_ff;
            dtx_ack_ff  <= ~dtx_ack_ff;
        end else if (dtx_end) begin
            dtx_busy_ff <= 1'b0;
        end else if (dtx_busy_ff) begin
            dtx_sh_ff  <= {dtx_sh_ff[6:0], 1'b1};
            dtx_cnt_ff <= dtx_cnt_ff + 3'h1;
        end
    end

    // Data receiver: start bit, then bytes while armed
    wire din       = spi ? link.cmd_line : link.dat_line;
    wire din_ok    = selected & arm_l & (spi ? ~rx_busy_ff : ~dtx_busy_ff);
    wire drx_start = ~drx_busy_ff & din_ok & ~din;
    wire drx_end   = drx_busy_ff & (drx_cnt_ff == `CIM_BYTE_LAST);
    always_ff @(posedge link.lclk or negedge NRST) begin
        if (!NRST) begin
            drx_busy_ff <= 1'b0;
            drx_cnt_ff  <= 3'h0;
            drx_sh_ff   <= 8'h00;
            drx_byte_ff <= 8'h00;
            drx_tgl_ff  <= 1'b0;
        end else if (drx_start) begin
            drx_busy_ff <= 1'b1;
            drx_cnt_ff  <= 3'h0;
        end else if (drx_busy_ff) begin
            drx_sh_ff  <= {drx_sh_ff[6:0], din};
            drx_cnt_ff <= drx_cnt_ff + 3'h1;
            if (drx_end) begin
                drx_byte_ff <= {drx_sh_ff[6:0], din};
                drx_tgl_ff  <= ~drx_tgl_ff;
                drx_busy_ff <= arm_l & selected;
            end
        end
    end

    // Pads; SPI idle output shows busy low while programming
    wire do_bit = rtx_busy_ff ? rtx_sh_ff[47] : (dtx_busy_ff ? dtx_sh_ff[7] : ~busy_s_ff[1]);
    assign link.cmd_c_oe = ~spi & rtx_busy_ff & (~od_l | ~rtx_sh_ff[47]);
    assign link.cmd_c_o  = ~od_l & rtx_sh_ff[47];
    assign link.dat_c_oe = spi ? ~link.cs_n : dtx_busy_ff;
    assign link.dat_c_o  = spi ? do_bit : dtx_sh_ff[7];

    // Core domain: crossings back from the link clock
    logic [2:0] cmd_s_ff, drx_s_ff;
    logic [1:0] spi_s_ff, rack_s_ff, dack_s_ff;
    logic       cmd_valid_ff, drx_valid_ff, blk_end_ff;
    cim_frame_t cmd_word_ff;
    cim_byte_t  drx_out_ff;
    cim_len_t   blk_cnt_ff;

    wire      dtx_take = DTX_VALID & DTX_READY;
    wire      len_bad  = (BLK_LEN == 12'h000) | (BLK_LEN > `CIM_BLK_MAX);
    cim_len_t len_eff;
    cim_len_t blk_nxt;
    assign len_eff = len_bad ? `CIM_BLK_MAX : BLK_LEN;
    assign blk_nxt = blk_cnt_ff + 12'h001;

    // Retiming into the internal clock; words are stable when the toggle lands
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            cmd_s_ff     <= 3'h0;
            drx_s_ff     <= 3'h0;
            spi_s_ff     <= 2'h0;
            rack_s_ff    <= 2'h0;
            dack_s_ff    <= 2'h0;
            cmd_valid_ff <= 1'b0;
            cmd_word_ff  <= '0;
            drx_valid_ff <= 1'b0;
            drx_out_ff   <= 8'h00;
        end else begin
            cmd_s_ff     <= {cmd_s_ff[1:0], frame_tgl_ff};
            drx_s_ff     <= {drx_s_ff[1:0], drx_tgl_ff};
            spi_s_ff     <= {spi_s_ff[0], spi};
            rack_s_ff    <= {rack_s_ff[0], rsp_ack_ff};
            dack_s_ff    <= {dack_s_ff[0], dtx_ack_ff};
            cmd_valid_ff <= tgl_edge(cmd_s_ff);
            drx_valid_ff <= tgl_edge(drx_s_ff);
            if (tgl_edge(cmd_s_ff)) cmd_word_ff <= frame_ff;
            if (tgl_edge(drx_s_ff)) drx_out_ff <= drx_byte_ff;
        end
    end

    // Core requests; PROG_BUSY is independent of select so programming runs on
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            od_core_ff   <= 1'b1;
            busy_core_ff <= 1'b0;
            arm_core_ff  <= 1'b0;
            rsp_req_ff   <= 1'b0;
            rsp_word_ff  <= '1;
            dtx_req_ff   <= 1'b0;
            dtx_byte_ff  <= 8'hFF;
            blk_cnt_ff   <= 12'h000;
            blk_end_ff   <= 1'b0;
        end else begin
            od_core_ff   <= OPEN_DRAIN;
            busy_core_ff <= PROG_BUSY;
            arm_core_ff  <= DRX_ARM;
            if (RESP_VALID & RESP_READY) begin
                rsp_word_ff <= RESP_WORD;
                rsp_req_ff  <= ~rsp_req_ff;
            end
            blk_end_ff <= dtx_take & (blk_nxt >= len_eff);
            if (dtx_take) begin
                dtx_byte_ff <= DTX_BYTE;
                dtx_req_ff  <= ~dtx_req_ff;
                blk_cnt_ff  <= (blk_nxt >= len_eff) ? 12'h000 : blk_nxt;
            end
        end
    end

    assign CMD_VALID   = cmd_valid_ff;
    assign CMD_WORD    = cmd_word_ff;
    assign SPI_MODE    = spi_s_ff[1];
    assign RESP_READY  = (rsp_req_ff == rack_s_ff[1]);
    assign DTX_READY   = (dtx_req_ff == dack_s_ff[1]);
    assign DTX_BLK_END = blk_end_ff;
    assign DRX_VALID   = drx_valid_ff;
    assign DRX_BYTE    = drx_out_ff;
endmodule : cim_card_end
`default_nettype wire

/* File: src/cim_host_end.sv */
// Host end of the card link: clock divider, command, response and data paths
`timescale 1ns/1ns
`default_nettype none
`include "cim_regs.svh"
module cim_host_end
    import cim_pkg::*;
(
    cim_link_if.host         link,
    input  wire logic        CLK,
    input  wire logic        NRST,
    input  wire logic        CLK_RUN,
    input  wire logic        SPI_SEL,
    input  wire logic        CS_HOLD,
    input  wire logic        OD_MODE,
    input  wire logic        CMD_VALID,
    input  wire cim_frame_t  CMD_WORD,
    output logic             CMD_READY,
    output logic             RESP_VALID,
    output cim_frame_t       RESP_WORD,
    output logic             SPI_ACTIVE,
    input  wire logic        DTX_VALID,
    input  wire cim_byte_t   DTX_BYTE,
    output logic             DTX_READY,
    input  wire logic        DRX_ARM,
    output logic             DRX_VALID,
    output cim_byte_t        DRX_BYTE
);
    logic [1:0] div_ff, cmd_s_ff, dat_s_ff;
    logic       lclk_ff, cs_n_ff;
    cim_mode_e  mode_ff;
    logic       cpend_ff, ctx_busy_ff, rst_cmd_ff, crx_arm_ff, crx_busy_ff, rvalid_ff;
    logic [5:0] ctx_cnt_ff, crx_cnt_ff;
    cim_frame_t ctx_sh_ff, crx_sh_ff, resp_ff;
    logic       dpend_ff, dtx_busy_ff, drx_busy_ff, dvalid_ff;
    logic [2:0] dtx_cnt_ff, drx_cnt_ff;
    cim_byte_t  dbyte_ff, dtx_sh_ff, drx_sh_ff, drx_out_ff;

    // Divider: half period rounded up keeps the link at or under 20 MHz
    wire spi    = (mode_ff == CIM_MODE_SPI);
    wire active = CLK_RUN | cpend_ff | ctx_busy_ff | crx_arm_ff | dpend_ff
                | dtx_busy_ff | drx_busy_ff | DRX_ARM;
    wire half   = (div_ff == 2'(`CIM_LCLK_HALF - 1));
    wire rise   = half & ~lclk_ff & active;
    wire fall   = half & lclk_ff;
    wire cmd_in = cmd_s_ff[1];
    wire dat_in = dat_s_ff[1];

    // Transmit decode, evaluated at the falling link edge
    wire ctx_start = fall & cpend_ff & ~ctx_busy_ff;
    wire ctx_done  = fall & ctx_busy_ff & (ctx_cnt_ff == 6'h01);
    wire dtx_end   = dtx_busy_ff & (dtx_cnt_ff == `CIM_BYTE_LAST);
    wire dtx_load  = fall & dpend_ff & (~dtx_busy_ff | dtx_end) & ~ctx_busy_ff;
    wire cs_low    = SPI_SEL & (CS_HOLD | ctx_busy_ff | ctx_start);

    // Receive decode, evaluated at the rising link edge
    wire rline     = spi ? dat_in : cmd_in;
    wire crx_start = rise & crx_arm_ff & ~crx_busy_ff & ~rline;
    wire crx_last  = rise & crx_busy_ff & (crx_cnt_ff == `CIM_FRAME_LAST);
    wire drx_ok    = DRX_ARM & ~crx_arm_ff & ~dtx_busy_ff;
    wire drx_start = rise & drx_ok & ~drx_busy_ff & ~dat_in;
    wire drx_end   = rise & drx_busy_ff & (drx_cnt_ff == `CIM_BYTE_LAST);

    // Clock generation and pin retiming
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            div_ff   <= 2'h0;
            lclk_ff  <= 1'b0;
            cmd_s_ff <= 2'h3;
            dat_s_ff <= 2'h3;
        end else begin
            div_ff   <= half ? 2'h0 : div_ff + 2'h1;
            if (rise | fall) lclk_ff <= ~lclk_ff;
            cmd_s_ff <= {cmd_s_ff[0], link.cmd_line};
            dat_s_ff <= {dat_s_ff[0], link.dat_line};
        end
    end

    // Command sender and select; response receiver is armed after each command
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            mode_ff     <= CIM_MODE_NATIVE;
            cs_n_ff     <= 1'b1;
            cpend_ff    <= 1'b0;
            rst_cmd_ff  <= 1'b0;
            ctx_busy_ff <= 1'b0;
            ctx_cnt_ff  <= 6'h00;
            ctx_sh_ff   <= '1;
            crx_arm_ff  <= 1'b0;
        end else begin
            if (fall) cs_n_ff <= ~cs_low;
            if (CMD_VALID & CMD_READY) begin
                cpend_ff   <= 1'b1;
                ctx_sh_ff  <= CMD_WORD;
                rst_cmd_ff <= (CMD_WORD[`CIM_IDX_MSB:`CIM_IDX_LSB] == `CIM_RESET_IDX);
            end
            if (ctx_start) begin
                cpend_ff    <= 1'b0;
                ctx_busy_ff <= 1'b1;
                ctx_cnt_ff  <= `CIM_FRAME_LEN;
            end else if (fall & ctx_busy_ff) begin
                ctx_sh_ff  <= {ctx_sh_ff[46:0], 1'b1};
                ctx_cnt_ff <= ctx_cnt_ff - 6'h01;
            end
            if (ctx_done) begin
                ctx_busy_ff <= 1'b0;
                crx_arm_ff  <= 1'b1;
                if (rst_cmd_ff & ~cs_n_ff) mode_ff <= CIM_MODE_SPI;
            end else if (crx_last) begin
                crx_arm_ff <= 1'b0;
            end
        end
    end

    // Response receiver
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            crx_busy_ff <= 1'b0;
            crx_cnt_ff  <= 6'h00;
            crx_sh_ff   <= '0;
            resp_ff     <= '0;
            rvalid_ff   <= 1'b0;
        end else begin
            rvalid_ff <= crx_last;
            if (crx_start | (rise & crx_busy_ff)) crx_sh_ff <= {crx_sh_ff[46:0], rline};
            if (crx_start) begin
                crx_busy_ff <= 1'b1;
                crx_cnt_ff  <= 6'h01;
            end else if (crx_last) begin
                crx_busy_ff <= 1'b0;
                resp_ff     <= {crx_sh_ff[46:0], rline};
            end else if (rise & crx_busy_ff) begin
                crx_cnt_ff <= crx_cnt_ff + 6'h01;
            end
        end
    end

    // Data sender and receiver
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            dpend_ff    <= 1'b0;
            dbyte_ff    <= 8'hFF;
            dtx_busy_ff <= 1'b0;
            dtx_cnt_ff  <= 3'h0;
            dtx_sh_ff   <= 8'hFF;
            drx_busy_ff <= 1'b0;
            drx_cnt_ff  <= 3'h0;
            drx_sh_ff   <= 8'h00;
            drx_out_ff  <= 8'h00;
            dvalid_ff   <= 1'b0;
        end else begin
            if (DTX_VALID & DTX_READY) begin
                dpend_ff <= 1'b1;
                dbyte_ff <= DTX_BYTE;
            end
            if (dtx_load) begin
                dpend_ff    <= 1'b0;
                dtx_busy_ff <= 1'b1;
                dtx_cnt_ff  <= 3'h0;
                dtx_sh_ff   <= dbyte_ff;
            end else if (fall & dtx_end) begin
                dtx_busy_ff <= 1'b0;
            end else if (fall & dtx_busy_ff) begin
                dtx_sh_ff  <= {dtx_sh_ff[6:0], 1'b1};
                dtx_cnt_ff <= dtx_cnt_ff + 3'h1;
            end
            dvalid_ff <= drx_end;
            if (drx_start) begin
                drx_busy_ff <= 1'b1;
                drx_cnt_ff  <= 3'h0;
            end else if (rise & drx_busy_ff) begin
                drx_sh_ff  <= {drx_sh_ff[6:0], dat_in};
                drx_cnt_ff <= drx_cnt_ff + 3'h1;
                if (drx_end) begin
                    drx_out_ff  <= {drx_sh_ff[6:0], dat_in};
                    drx_busy_ff <= drx_ok;
                end
            end
        end
    end

    // Pads: SPI uses the command pad as data in, push-pull and idling high
    wire di_bit = ctx_busy_ff ? ctx_sh_ff[47] : (dtx_busy_ff ? dtx_sh_ff[7] : 1'b1);
    assign link.lclk     = lclk_ff;
    assign link.cs_n     = cs_n_ff;
    assign link.cmd_h_oe = spi | (ctx_busy_ff & (~OD_MODE | ~ctx_sh_ff[47]));
    assign link.cmd_h_o  = spi ? di_bit : (~OD_MODE & ctx_busy_ff & ctx_sh_ff[47]);  // Drives only low in OD_MODE outside SPI, else drives both levels
    assign link.dat_h_oe = ~spi & dtx_busy_ff;
    assign link.dat_h_o  = dtx_sh_ff[7];

    assign CMD_READY  = ~cpend_ff & ~ctx_busy_ff & ~crx_arm_ff;
    assign RESP_VALID = rvalid_ff;
    assign RESP_WORD  = resp_ff;
    assign SPI_ACTIVE = spi;
    assign DTX_READY  = ~dpend_ff;
    assign DRX_VALID  = dvalid_ff;
    assign DRX_BYTE   = drx_out_ff;
endmodule : cim_host_end
`default_nettype wire

/* File: verification/cim_link_chk.sv */
// Assertions on the card link wires
`timescale 1ns/1ns
`default_nettype none
module cim_link_chk (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic lclk,
    input wire logic cs_n,
    input wire logic cmd_h_o,
    input wire logic cmd_h_oe,
    input wire logic cmd_c_o,
    input wire logic cmd_c_oe,
    input wire logic dat_h_oe,
    input wire logic dat_c_oe
);
    logic spi_ff;
    // Select seen low marks the link as SPI; only reset leaves it
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) spi_ff <= 1'b0;
        else if (!cs_n) spi_ff <= 1'b1;
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    // Pad ownership, timing of the link clock and select
    rst_idle_a: assert property ($rose(NRST) |-> !lclk && cs_n && !cmd_h_oe && !dat_c_oe)
        else $error("link not idle after reset");
    cmd_owner_a: assert property (!(cmd_h_oe && cmd_c_oe))
        else $error("both ends drive command pad");
    dat_owner_a: assert property (!(dat_h_oe && dat_c_oe))
        else $error("both ends drive data pad");
    lclk_half_a: assert property ($rose(lclk) |-> lclk[*3] ##1 !lclk)
        else $error("link clock high phase not three cycles");
    host_setup_a: assert property ($rose(lclk) |-> $stable(cmd_h_o))
        else $error("host command bit moved at sampling edge");
    card_hold_a: assert property ($fell(lclk) |-> $stable(cmd_c_o))
        else $error("card command bit moved at falling edge");
    spi_no_cmd_a: assert property (spi_ff |-> !cmd_c_oe)
        else $error("card drives command pad in SPI");
    desel_quiet_a: assert property ((spi_ff && cs_n)[*3] |-> !dat_c_oe)
        else $error("card drives data out while deselected");
    cs_hold_a: assert property ($fell(cs_n) |-> !cs_n[*8])
        else $error("select released too early");
    cover property ($fell(cs_n));
    cover property (cmd_c_oe && !cmd_c_o);
    cover property (dat_c_oe && !cs_n);
endmodule : cim_link_chk
`default_nettype wire

/* File: verification/tb_card_interface_mode_front_end.sv */
// Testbench: host end and card end joined over the card link
`timescale 1ns/1ns
`default_nettype none
module tb_card_interface_mode_front_end import cim_pkg::*; ;
    logic       clk, nrst, od, busy, spi_sel, cs_hold, h_cmd_v, c_rsp_v, c_tx_v, h_rx_arm, seen;
    logic       c_cmd_v, c_spi, c_rsp_rdy, c_tx_rdy, c_blk_end, h_cmd_rdy, h_rsp_v, h_spi, h_rx_v;
    cim_frame_t h_cmd_w, c_cmd_w, c_rsp_w, h_rsp_w;
    logic       h_tx_v, h_tx_rdy, c_rx_arm, c_rx_v;
    cim_byte_t  c_tx_b, h_rx_b, h_tx_b, c_rx_b;
    int         err_total, num_checks, blk_cnt;
    cim_link_if link ();
    cim_host_end u_cim_host_end (.link(link.host), .CLK(clk), .NRST(nrst), .CLK_RUN(1'b0),
        .SPI_SEL(spi_sel), .CS_HOLD(cs_hold), .OD_MODE(od), .CMD_VALID(h_cmd_v),
        .CMD_WORD(h_cmd_w), .CMD_READY(h_cmd_rdy), .RESP_VALID(h_rsp_v), .RESP_WORD(h_rsp_w),
        .SPI_ACTIVE(h_spi), .DTX_VALID(h_tx_v), .DTX_BYTE(h_tx_b), .DTX_READY(h_tx_rdy),
        .DRX_ARM(h_rx_arm), .DRX_VALID(h_rx_v), .DRX_BYTE(h_rx_b));
    cim_card_end u_cim_card_end (.link(link.card), .CLK(clk), .NRST(nrst), .CMD_VALID(c_cmd_v),
        .CMD_WORD(c_cmd_w), .SPI_MODE(c_spi), .RESP_VALID(c_rsp_v), .RESP_WORD(c_rsp_w),
        .RESP_READY(c_rsp_rdy), .OPEN_DRAIN(od), .PROG_BUSY(busy), .DTX_VALID(c_tx_v),
        .DTX_BYTE(c_tx_b), .DTX_READY(c_tx_rdy), .BLK_LEN(12'h002), .DTX_BLK_END(c_blk_end),
        .DRX_ARM(c_rx_arm), .DRX_VALID(c_rx_v), .DRX_BYTE(c_rx_b));
    cim_link_chk u_cim_link_chk (.CLK(clk), .NRST(nrst), .lclk(link.lclk), .cs_n(link.cs_n),
        .cmd_h_o(link.cmd_h_o), .cmd_h_oe(link.cmd_h_oe), .cmd_c_o(link.cmd_c_o),
        .cmd_c_oe(link.cmd_c_oe), .dat_h_oe(link.dat_h_oe), .dat_c_oe(link.dat_c_oe));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Block ends are counted as they pass
    always @(posedge c_blk_end) blk_cnt++;
    task automatic chk(input string what, input cim_frame_t exp, input cim_frame_t got);
        num_checks++;
        if (exp !== got) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic send(input cim_frame_t cmd);
        @(negedge clk) h_cmd_v = 1'b1;
        h_cmd_w = cmd;
        while (h_cmd_rdy !== 1'b1) @(negedge clk);
        @(negedge clk) h_cmd_v = 1'b0;
    endtask : send
    // One command frame out, one response frame back
    task automatic xfer(input cim_frame_t cmd, input cim_frame_t rsp);
        send(cmd);
        @(posedge c_cmd_v) @(negedge clk) chk("command", cmd, c_cmd_w);
        c_rsp_v = 1'b1;
        c_rsp_w = rsp;
        while (c_rsp_rdy !== 1'b1) @(negedge clk);
        @(negedge clk) c_rsp_v = 1'b0;
        @(posedge h_rsp_v) @(negedge clk) chk("response", rsp, h_rsp_w);
    endtask : xfer
    task automatic htx(input cim_byte_t b);
        @(negedge clk) h_tx_v = 1'b1;
        h_tx_b = b;
        while (h_tx_rdy !== 1'b1) @(negedge clk);
        @(negedge clk) h_tx_v = 1'b0;
    endtask : htx
    task automatic ctx(input cim_byte_t b);
        @(negedge clk) c_tx_v = 1'b1;
        c_tx_b = b;
        while (c_tx_rdy !== 1'b1) @(negedge clk);
        @(negedge clk) c_tx_v = 1'b0;
    endtask : ctx
    task automatic finish_test();
        $display("Checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    // Watchdog well beyond the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        finish_test();
    end
    initial begin
        {nrst, h_cmd_v, c_rsp_v, c_tx_v, h_rx_arm, spi_sel, cs_hold, busy, seen} = '0;
        {h_tx_v, c_rx_arm} = '0;
        {od, h_cmd_w, c_rsp_w, c_tx_b, h_tx_b, blk_cnt, err_total, num_checks} = '0;
        od = 1'b1;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        chk("mode at start", 48'h0, {47'h0, c_spi});
        xfer(48'h7A_1234_5678_9B, 48'h3C_8765_4321_0F);
        od = 1'b0;
        xfer(48'h55_AAAA_0000_C3, 48'h0F_0000_FFFF_A1);
        $display("native command test done");
        // FE ends in the start bit, so A5 is the first byte seen
        h_rx_arm = 1'b1;
        ctx(8'hFE);
        ctx(8'hA5);
        @(posedge h_rx_v) @(negedge clk) chk("data byte", 48'hA5, {40'h0, h_rx_b});
        h_rx_arm = 1'b0;
        chk("block ends", 48'h1, 48'(blk_cnt));
        $display("native data test done");
        spi_sel = 1'b1;
        cs_hold = 1'b1;
        xfer(48'h40_0000_0000_95, 48'h01_0000_0000_01);
        chk("spi mode", 48'h3, {46'h0, c_spi, h_spi});
        xfer(48'h51_0000_0200_FF, 48'h00_1111_2222_33);
        // FE ends in the start bit on data in, so 3C is the byte the card takes
        c_rx_arm = 1'b1;
        htx(8'hFE);
        htx(8'h3C);
        @(posedge c_rx_v) @(negedge clk) chk("spi data in", 48'h3C, {40'h0, c_rx_b});
        c_rx_arm = 1'b0;
        // Deselected card with programming busy must stay silent
        {cs_hold, spi_sel, busy} = 3'h1;
        send(48'h4D_0000_0000_01);
        repeat (600) @(negedge clk) seen |= (c_cmd_v !== 1'b0);
        chk("deselected command", 48'h0, {47'h0, seen});
        chk("data out released", 48'h1, {47'h0, link.dat_line});
        $display("spi test done");
        finish_test();
    end
endmodule : tb_card_interface_mode_front_end
`default_nettype wire
